// File: rtl/tws_fifo.sv
// Small synchronous FIFO for received bytes
`timescale 1ns/1ps
`default_nettype none
module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;
    // Honest full and empty from the fill count
    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    // Storage write
    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end
    // Pointers and fill count
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWrite) wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            if (doRead) rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule
`default_nettype wire

// File: rtl/tws_pkg.sv
// Shared constants for the two-wire bus address phase block
package tws_pkg;
    localparam int TWS_BYTE_BITS = 8;
    localparam int TWS_DONE_EDGE = 9;
    localparam logic [7:0] TWS_BUF_RESET = 8'hFF;
    localparam logic [3:0] TWS_CNT_RESET = 4'h0;
    localparam int TWS_FIFO_DEPTH = 8;
    typedef enum logic [1:0] {
        TWS_IDLE = 2'b00,
        TWS_ADDR = 2'b01,
        TWS_CMD = 2'b10,
        TWS_DATA = 2'b11
    } tws_frame_t;
endpackage

// File: rtl/tws_slave.sv
// Two-wire bus slave station: clock sampling, conditions, address frame
// Functional notes
// - A byte moves in the first 8 clock cycles, the ninth cycle is handshake.
// - The address is eight bits sent most significant bit first, bit 7 to bit 0.
// - A received address byte is taken as the identity of the slave being selected.
// - A shift buffer write with the unit enabled starts a transfer ending in a request on edge 9.
// - With the wake-up filter off the request sets on every 9th rise, else only on own address.
`timescale 1ns/1ps
`default_nettype none
module tws_slave
    import tws_pkg::*;
#(
    parameter int FIFO_DEPTH = TWS_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic serialClock,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    input wire logic serialUnitEnable,
    input wire logic wakeupAddressFilter,
    input wire logic [7:0] ownSlaveAddress,
    input wire logic [7:0] shiftBufferWrData,
    input wire logic shiftBufferWrite,
    output logic [7:0] shiftBuffer,
    output logic transferDoneRequest,
    output logic addressMatch,
    output logic busReleaseSeen,
    output logic commandSeen,
    output logic [1:0] frameKind,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic rxOverflow
);
    // Two-flop synchronisers for the pins; reset to the idle high level
    // so that neither a false clock edge nor a false condition follows reset
    logic sckMeta, sckSync, sckLast;
    logic sdaMeta, sdaSync, sdaLast;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sckMeta <= 1'b1;
            sckSync <= 1'b1;
            sckLast <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaLast <= 1'b1;
        end else begin
            sckMeta <= serialClock;
            sckSync <= sckMeta;
            sckLast <= sckSync;
            sdaMeta <= serialDataIn;
            sdaSync <= sdaMeta;
            sdaLast <= sdaSync;
        end
    end

    wire sckRise = sckSync && !sckLast;
    wire sckFall = !sckSync && sckLast;
    wire relCond = sckSync && sckLast && sdaSync && !sdaLast;
    wire cmdCond = sckSync && sckLast && !sdaSync && sdaLast;

    // Software load of the buffer, honoured only with the unit enabled
    wire loadStrobe = shiftBufferWrite && serialUnitEnable;

    logic [3:0] bitCount;
    logic [3:0] next_bitCount;
    logic [7:0] next_shiftBuffer;
    logic [7:0] loadValue;
    logic active;
    tws_frame_t frame;
    logic relPending;
    logic fifoInReady;
    logic ninthRise;
    logic isAddrByte;
    logic ownMatch;
    logic raiseReq;

    // True while the current byte still has bits to move
    // Shared by the counter, the shift and the line driver
    function automatic logic in_byte(input logic [3:0] count);
        return count < 4'(TWS_BYTE_BITS);
    endfunction

    assign ninthRise = active && sckRise && (bitCount == 4'(TWS_DONE_EDGE - 1));
    assign isAddrByte = (frame == TWS_ADDR);
    assign ownMatch = isAddrByte && (shiftBuffer == ownSlaveAddress);
    assign raiseReq = ninthRise && (!wakeupAddressFilter || ownMatch);
    assign next_bitCount = in_byte(bitCount) ? bitCount + 4'h1 : bitCount;
    // MSB first shift; sample on rise
    assign next_shiftBuffer = {shiftBuffer[6:0], sdaSync};

    // Bit counter and transfer activity
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bitCount <= TWS_CNT_RESET;
            active <= 1'b0;
        end else if (relCond || cmdCond) begin
            bitCount <= TWS_CNT_RESET;
        end else if (loadStrobe) begin
            bitCount <= TWS_CNT_RESET;
            active <= 1'b1;
        end else if (!serialUnitEnable) begin
            active <= 1'b0;
            bitCount <= TWS_CNT_RESET;
        end else if (ninthRise) begin
            bitCount <= TWS_CNT_RESET;
        end else if (active && sckRise) begin
            bitCount <= next_bitCount;
        end
    end

    // Shift buffer: software load or serial shift
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            shiftBuffer <= TWS_BUF_RESET;
        end else if (loadStrobe) begin
            shiftBuffer <= shiftBufferWrData;
        // A condition cancels any rise that led into it: restart from the load
        end else if (relCond || cmdCond) begin
            shiftBuffer <= loadValue;
        // sample during first eight rises, hold after
        end else if (active && sckRise && in_byte(bitCount)) begin
            shiftBuffer <= next_shiftBuffer;
        end
    end

    // Copy of the last load, replayed when a condition restarts the byte;
    // the master's clock rise ahead of a release would otherwise eat a bit
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            loadValue <= TWS_BUF_RESET;
        end else if (loadStrobe) begin
            loadValue <= shiftBufferWrData;
        end
    end

    // frame kind after release and command conditions
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            frame <= TWS_IDLE;
            relPending <= 1'b0;
            busReleaseSeen <= 1'b0;
            commandSeen <= 1'b0;
        end else begin
            if (relCond) begin
                relPending <= 1'b1;
                busReleaseSeen <= 1'b1;
                commandSeen <= 1'b0;
            end else if (cmdCond) begin
                frame <= relPending ? TWS_ADDR : TWS_CMD;
                relPending <= 1'b0;
                commandSeen <= 1'b1;
            end else if (ninthRise) begin
                frame <= TWS_DATA;
                busReleaseSeen <= 1'b0;
                commandSeen <= 1'b0;
            end
        end
    end

    // Drive line: open drain pulls low for zero bits while sending
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serialDataOe <= 1'b0;
            serialDataOut <= 1'b0;
            transferDoneRequest <= 1'b0;
            addressMatch <= 1'b0;
            frameKind <= TWS_IDLE;
            rxOverflow <= 1'b0;
        end else begin
            serialDataOut <= 1'b0;
            // Next bit goes out at each falling clock while the byte moves
            if (sckFall) begin
                serialDataOe <= in_byte(bitCount) && !shiftBuffer[7];
            end
            // Release on a load, at the byte end, when idle and while filtering;
            // a pull at load time would fake a command condition on the bus
            if (loadStrobe || !active || ninthRise || wakeupAddressFilter) begin
                serialDataOe <= 1'b0;
            end
            transferDoneRequest <= raiseReq;
            if (ninthRise) begin
                addressMatch <= ownMatch;
            end
            frameKind <= frame;
            rxOverflow <= ninthRise && !fifoInReady;
        end
    end

    // Received bytes go to the FIFO on each completed byte that raises the request
    // A byte that finds the queue full is dropped and flagged as overflow,
    // so software must drain the queue at least once per eight bytes
    tws_fifo #(
        .WIDTH(TWS_BYTE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) rxFifo (
        .mclk(mclk),
        .nrst(nrst),
        .inData(shiftBuffer),
        .inValid(raiseReq),
        .inReady(fifoInReady),
        .outData(rxData),
        .outValid(rxValid),
        .outReady(rxReady)
    );
endmodule
`default_nettype wire

// File: sim/two_wire_bus_clock_address_phase_tb_top.sv
// Testbench for the two-wire slave station
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_clock_address_phase_tb_top;
    import tws_pkg::*;
    logic mclk = 0, nrst = 0, serialUnitEnable = 1, wakeupAddressFilter = 0;
    logic shiftBufferWrite = 0, rxReady = 0;
    logic [7:0] ownSlaveAddress = 8'h00, shiftBufferWrData = 8'hFF;
    logic serialClock, masterData, serialDataOut, serialDataOe, transferDoneRequest;
    logic addressMatch, busReleaseSeen, commandSeen, rxValid, rxOverflow;
    logic [1:0] frameKind;
    logic [7:0] shiftBuffer, rxData;
    logic [7:0] q[$];
    int errors = 0, checked = 0, reqs = 0, ovfs = 0, cyc = 0, oes = 0;
    logic [1:0] kindSeen = 2'b00, flagSeen = 2'b00;
    logic [7:0] addr;
    // Open-drain line with pull-up
    wire logic serialDataIn = masterData & ~serialDataOe;
    always #10 mclk = ~mclk;
    tws_slave i_dut (
        .mclk(mclk),
        .nrst(nrst),
        .serialClock(serialClock),
        .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe),
        .serialUnitEnable(serialUnitEnable),
        .wakeupAddressFilter(wakeupAddressFilter),
        .ownSlaveAddress(ownSlaveAddress),
        .shiftBufferWrData(shiftBufferWrData),
        .shiftBufferWrite(shiftBufferWrite),
        .shiftBuffer(shiftBuffer),
        .transferDoneRequest(transferDoneRequest),
        .addressMatch(addressMatch),
        .busReleaseSeen(busReleaseSeen),
        .commandSeen(commandSeen),
        .frameKind(frameKind),
        .rxData(rxData),
        .rxValid(rxValid),
        .rxReady(rxReady),
        .rxOverflow(rxOverflow)
    );
    tws_master_model i_master (
        .serialClock(serialClock),
        .masterData(masterData)
    );
    // Pulse counters and hang guard
    always @(posedge mclk) begin
        reqs += transferDoneRequest;
        ovfs += rxOverflow;
        oes += serialDataOe;
        if (++cyc == 12000) begin
            errors++;
            report_and_stop();
        end
    end
    // Frame kind and condition flags as they stand in the ninth bit cycle
    always @(negedge serialClock) begin
        kindSeen = frameKind;
        flagSeen = {busReleaseSeen, commandSeen};
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [1:0] kind_of(input bit bus_release_condition, input bit cmd);
        return bus_release_condition ? TWS_ADDR : (cmd ? TWS_CMD : TWS_DATA);
    endfunction
    task automatic run(input bit bus_release_condition, input bit cmd, input logic [7:0] b);
        @(posedge mclk) shiftBufferWrite <= 1;
        @(posedge mclk) shiftBufferWrite <= 0;
        i_master.frame(bus_release_condition, cmd, b);
        repeat (8) @(posedge mclk);
        check(8'(kindSeen), 8'(kind_of(bus_release_condition, cmd)));
        check({7'h0, flagSeen[1]}, {7'h0, bus_release_condition});
        check({7'h0, flagSeen[0]}, {7'h0, cmd});
    endtask
    task automatic pop(input logic [7:0] exp);
        @(negedge mclk) check({7'h0, rxValid}, 8'h1);
        check(rxData, exp);
        @(posedge mclk) rxReady <= 1;
        @(posedge mclk) rxReady <= 0;
    endtask
    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence: fill, frame kinds, address filter
    initial begin
        void'($urandom(11));
        repeat (2) @(posedge mclk);
        nrst <= 1;
        @(negedge mclk) check(shiftBuffer, 8'hFF);
        check({7'h0, rxValid}, 8'h0);
        q = '{8'h01, 8'hFE};
        repeat (7) q.push_back(8'($urandom));
        foreach (q[i]) run(1, 1, q[i]);
        check(8'(reqs), 8'h9);
        check(8'(ovfs), 8'h1);
        for (int i = 0; i < 8; i++) pop(q[i]);
        $display("test fill done");
        run(0, 1, 8'h5A);
        pop(8'h5A);
        run(0, 0, 8'hA5);
        pop(8'hA5);
        $display("test kinds done");
        wakeupAddressFilter <= 1;
        addr = 8'($urandom);
        ownSlaveAddress <= addr;
        reqs = 0;
        run(1, 1, addr ^ 8'h01);
        check(8'(reqs), 8'h0);
        check({7'h0, rxValid}, 8'h0);
        run(1, 1, addr);
        check({7'h0, addressMatch}, 8'h1);
        pop(addr);
        check(8'(reqs), 8'h1);
        check(8'(oes), 8'h0);
        $display("test filter done");
        report_and_stop();
    end
endmodule
bind tws_slave tws_slave_chk i_chk (
    .mclk(mclk),
    .nrst(nrst),
    .wakeupAddressFilter(wakeupAddressFilter),
    .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe),
    .transferDoneRequest(transferDoneRequest),
    .addressMatch(addressMatch),
    .frameKind(frameKind),
    .rxData(rxData),
    .rxValid(rxValid),
    .rxReady(rxReady),
    .rxOverflow(rxOverflow)
);
`default_nettype wire

// File: sim/tws_master_model.sv
// Behavioural master station driving clock and data
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
    output logic serialClock,
    output logic masterData
);
    // Idle bus: clock parked high, data released to the pull-up
    initial begin
        serialClock = 1'b1;
        masterData = 1'b1;
    end
    // byte MSB first, ninth cycle released
    task automatic frame(input bit bus_release_condition, input bit cmd, input logic [7:0] b);
        // Step off the system clock edge so pins never race the sampling flops
        #5;
        if (bus_release_condition) begin
            serialClock = 1'b0;
            #40 masterData = 1'b0;
            #40 serialClock = 1'b1;
            #40 masterData = 1'b1;
            #40;
        end
        if (cmd) begin
            masterData = 1'b0;
            #40;
        end
        for (int i = 0; i < 9; i++) begin
            serialClock = 1'b0;
            masterData = (i < 8) ? b[7-i] : 1'b1;
            #80 serialClock = 1'b1;
            #80;
        end
    endtask
endmodule
`default_nettype wire

// File: sim/tws_slave_chk.sv
// Port checker for the two-wire slave station
`timescale 1ns/1ps
`default_nettype none
module tws_slave_chk
    import tws_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wakeupAddressFilter,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic transferDoneRequest,
    input wire logic addressMatch,
    input wire logic [1:0] frameKind,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic rxOverflow
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Request pulse and its spacing
    req_gap_a: assert property (transferDoneRequest |=> !transferDoneRequest [*8])
        else $error("request not one short pulse");
    // Filtered requests need a matching address frame
    filter_match_a: assert property (wakeupAddressFilter && transferDoneRequest |-> addressMatch)
        else $error("filtered request without match");
    filter_kind_a: assert property (wakeupAddressFilter && transferDoneRequest |-> frameKind == TWS_ADDR)
        else $error("filtered request outside address frame");
    // Received byte reaches the queue with the request
    req_byte_a: assert property (transferDoneRequest |-> rxValid)
        else $error("request without queued byte");
    hold_byte_a: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
        else $error("queued byte lost before taken");
    overflow_full_a: assert property (rxOverflow |-> rxValid)
        else $error("overflow with empty queue");
    // Open-drain line behaviour
    filter_quiet_a: assert property (wakeupAddressFilter && $past(wakeupAddressFilter) |-> !serialDataOe)
        else $error("line driven while filtering");
    drain_low_a: assert property (!serialDataOut)
        else $error("data output not low");
endmodule
`default_nettype wire
